// ==== rswe_reset_scope.sv ====
// How it works
// - wake mask: seven RW bits, sources 0..6, reset zero, 31:7 unused
// - mask one lets that source wake asynchronously; zero blocks it
// - flags read-only: bit 7 event clock, bits 3:0 buses D..A present
// - revision read-only: version 11:0, variant 19:16, no behaviour
// - rc calib, voltage calib and 32 kHz oscillator cleared only by power-on
// - async timer registers except interrupts cleared only by power-on
// - debug system cleared by all resets except watchdog and debug
// - watchdog ctrl spared by watchdog reset; brown-out ctrl by brown-out
// - every reset clears osc, supply, clock ctrl and cpu/bus fabric
//
// Added by the designer: the AHB-Lite interface to the registers.
`include "rswe_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rswe_reset_scope #(
    parameter logic event_clock_present = 1'b1,
    parameter logic [3:0] periph_bus_present = 4'hf,
    // arbitrary neutral values
    parameter logic [11:0] version_number = 12'h001,
    parameter logic [3:0] variant_number = 4'h0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [6:0] wake_request,
    output logic [6:0] wake_async,
    input wire rswe_pkg::rswe_rst_events_s rst_events,
    output rswe_pkg::rswe_clear_groups_s clear_groups
);

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    rswe_pkg::rswe_dphase_e dphase;
    logic [11:0] dp_addr;
    logic [6:0] wake_mask;
    logic [31:0] next_rdata;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase <= rswe_pkg::RSWE_DP_IDLE;
            dp_addr <= 12'h000;
        end else if (hready) begin
            if (hsel && htrans[1]) begin
                dphase <= hwrite ? rswe_pkg::RSWE_DP_WRITE : rswe_pkg::RSWE_DP_READ;
                dp_addr <= haddr[11:0];
            end else begin
                dphase <= rswe_pkg::RSWE_DP_IDLE;
            end
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_mask <= `RSWE_WAKE_MASK_RST;
        end else if (dphase == rswe_pkg::RSWE_DP_WRITE && dp_addr == `RSWE_WAKE_MASK_OFS) begin
            wake_mask <= hwdata[`RSWE_WAKE_SRC_N-1:0];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (dp_addr)
            `RSWE_WAKE_MASK_OFS: next_rdata[`RSWE_WAKE_SRC_N-1:0] = wake_mask;
            `RSWE_FLAGS_OFS: begin
                next_rdata[`RSWE_FLAG_EVCLK_BIT] = event_clock_present;
                next_rdata[3:0] = periph_bus_present;
            end
            `RSWE_REVISION_OFS: begin
                next_rdata[`RSWE_REV_VERSION_W-1:0] = version_number;
                next_rdata[`RSWE_REV_VARIANT_LSB +: `RSWE_REV_VARIANT_W] = variant_number;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data registered-free: valid in the data phase only
    assign hrdata = (dphase == rswe_pkg::RSWE_DP_READ) ? next_rdata : 32'h0000_0000;

    // ----------------------------------------
    // wake gating
    // ----------------------------------------
    // combinational on purpose: wake must pass while the bus clock is stopped
    assign wake_async = wake_request & wake_mask;

    // ----------------------------------------
    // reset scope
    // ----------------------------------------
    logic any_rst;
    assign any_rst = |rst_events;

    // a sparing event spares its group only when no non-sparing event comes with it; any non-sparing event still clears
    function automatic logic clears_unless(
        input rswe_pkg::rswe_rst_events_s ev,
        input logic [7:0] spared
    );
        return |(ev & ~spared);
    endfunction : clears_unless

    always_comb begin
        clear_groups.bus_fabric = any_rst;
        clear_groups.other_osc_ctrl = any_rst;
        clear_groups.supply_mon_ctrl = any_rst;
        clear_groups.clock_ctrl = any_rst;
        clear_groups.osc32k_state = rst_events.por;
        clear_groups.rc_calib = rst_events.por;
        clear_groups.volt_calib = rst_events.por;
        clear_groups.async_timer = rst_events.por;
        clear_groups.wdt_ctrl = clears_unless(rst_events, 8'h20);
        clear_groups.bod_ctrl = clears_unless(rst_events, 8'h10);
        clear_groups.on_chip_debug = clears_unless(rst_events, 8'h22);
    end

endmodule : rswe_reset_scope

`default_nettype wire

// ==== rswe_params.svh ====
`ifndef RSWE_PARAMS_SVH
`define RSWE_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSWE_WAKE_MASK_OFS 12'h188
`define RSWE_FLAGS_OFS 12'h3f8
`define RSWE_REVISION_OFS 12'h3fc

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define RSWE_WAKE_SRC_N 7
`define RSWE_WAKE_MASK_RST 7'h00
`define RSWE_FLAG_EVCLK_BIT 7
`define RSWE_REV_VERSION_W 12
`define RSWE_REV_VARIANT_LSB 16
`define RSWE_REV_VARIANT_W 4

`endif

// ==== rswe_pkg.sv ====
package rswe_pkg;

    // reset events that reach the manager, one bit each
    typedef struct packed {
        logic por;
        logic ext;
        logic wdt;
        logic brown_out_detector;
        logic supply_mon;
        logic cpu_err;
        logic debug;
        logic jtag;
    } rswe_rst_events_s;

    // clear strobes to the register groups
    typedef struct packed {
        logic bus_fabric;
        logic osc32k_state;
        logic rc_calib;
        logic other_osc_ctrl;
        logic async_timer;
        logic wdt_ctrl;
        logic volt_calib;
        logic supply_mon_ctrl;
        logic bod_ctrl;
        logic clock_ctrl;
        logic on_chip_debug;
    } rswe_clear_groups_s;

    typedef enum logic [1:0] {
        RSWE_DP_IDLE = 2'b00,
        RSWE_DP_READ = 2'b01,
        RSWE_DP_WRITE = 2'b10
    } rswe_dphase_e;

endpackage : rswe_pkg

// ==== rswe_reset_scope_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module rswe_reset_scope_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [6:0] wake_request,
    input wire logic [6:0] wake_async,
    input wire rswe_pkg::rswe_rst_events_s rst_events,
    input wire rswe_pkg::rswe_clear_groups_s clear_groups
);
    wire logic [10:0] cg = clear_groups;
    wire logic [7:0] ev = rst_events;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence acc_s(a, w);
        hsel && hready && htrans[1] && hwrite == w && haddr == a;
    endsequence
    wake_gate_a: assert property ((wake_async & ~wake_request) == 7'h0)
        else $error("wake gate");
    mask_write_a: assert property (acc_s(32'h188, 1'b1) ##1 1'b1 |=>
        wake_async == (wake_request & $past(hwdata[6:0]))) else $error("mask write");
    bus_fabric_a: assert property ({cg[10], cg[7], cg[3], cg[1]} == {4{|ev}})
        else $error("fabric clear");
    por_only_a: assert property ({cg[9], cg[8], cg[6], cg[4]} == {4{ev[7]}})
        else $error("por clear");
    debug_scope_a: assert property (cg[0] == |(ev & 8'hdd))
        else $error("debug clear");
    wdt_bod_a: assert property (cg[5] == |(ev & 8'hdf) && cg[2] == |(ev & 8'hef))
        else $error("wdt bod clear");
    flag_read_a: assert property (acc_s(32'h3f8, 1'b0) |=> hrdata == 32'h8f)
        else $error("flag read");
    unmapped_read_a: assert property (acc_s(32'h100, 1'b0) |=> hrdata == 32'h0)
        else $error("unmapped read");
endmodule : rswe_reset_scope_checker
bind rswe_reset_scope rswe_reset_scope_checker i_rswe_reset_scope_checker (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .wake_request, .wake_async,
    .rst_events, .clear_groups);
`default_nettype wire

// ==== rswe_reset_scope_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rswe_reset_scope_test;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pr = 1'b0, rd_ph = 1'b0;
    logic hreadyout;
    logic [1:0] htrans = 2'h0;
    logic [6:0] wake_request = 7'h0, wake_async;
    logic [7:0] ev;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    rswe_pkg::rswe_rst_events_s rst_events = 8'h0;
    rswe_pkg::rswe_clear_groups_s clear_groups;
    logic [31:0] rq[$], pq[$];
    int errors = 0, checks = 0, i;
    rswe_reset_scope i_rswe_reset_scope (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .wake_request,
        .wake_async, .rst_events, .clear_groups);
    always #5 hclk = ~hclk;
    task automatic end_of_test();
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : cmp
    // no fixed latency assumed: wait for ready, bounded
    task automatic wt();
        int n = 0;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
        if (n > 98) begin
            errors++;
            end_of_test();
        end
    endtask : wt
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        if (!w) rq.push_back(d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt();
    endtask : bus
    function automatic logic [10:0] clr(input logic [7:0] v);
        return {|v, v[7], v[7], |v, v[7], |(v & 8'hdf), v[7], |v, |(v & 8'hef), |v, |(v & 8'hdd)};
    endfunction : clr
    always @(posedge hclk) begin
        if (rd_ph) cmp("hrdata", rq.pop_front(), hrdata);
        if (pr) cmp("outputs", pq.pop_front(), {14'h0, clear_groups, wake_async});
        rd_ph <= hsel && htrans[1] && !hwrite;
    end
    initial begin
        void'($urandom(32'he18e));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(32'h188, 1'b0, 32'h0);
        bus(32'h100, 1'b0, 32'h0);
        for (i = 0; i < 12; i++) begin
            d = $urandom;
            ev = i < 8 ? 8'h1 << i : 8'($urandom);
            bus(32'h188, 1'b1, d);
            bus(i[0] ? 32'h3f8 : 32'h3fc, 1'b1, d);
            bus(32'h188, 1'b0, {25'h0, d[6:0]});
            wake_request <= d[13:7];
            rst_events <= ev;
            pq.push_back({14'h0, clr(ev), d[13:7] & d[6:0]});
            pr <= 1'b1;
            @(posedge hclk);
            pr <= 1'b0;
        end
        bus(32'h3f8, 1'b0, 32'h8f);
        bus(32'h3fc, 1'b0, 32'h1);
        end_of_test();
    end
endmodule : rswe_reset_scope_test
`default_nettype wire
